// ### logic/lpgc_pkg.sv
// Shared constants of the low power gating control block.
// Assumes a single 200 MHz core clock and a plain strobe register port.
package lpgc_pkg;

    // ========================================================
    // Register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ========================================================
    // Register offsets (byte addresses, one word each)
    localparam logic [7:0] OFS_CLK_CTRL = 8'h00;
    localparam logic [7:0] OFS_TMR_CUT = 8'h04;
    localparam logic [7:0] OFS_FLASH_CTRL = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;

    // ========================================================
    // Field positions of the clock control register
    localparam int BIT_PERIPH_STOP = 0;
    localparam int BIT_SRC_SEL = 1;
    localparam int BIT_OSC_SPEED = 2;
    localparam int CLK_CTRL_W = 3;

    // Field positions of the timer cutoff register
    localparam int BIT_CUT_A = 0;
    localparam int BIT_CUT_B = 1;
    localparam int TMR_CUT_W = 2;

    // Field positions of the flash control register
    localparam int BIT_FLASH_STOP = 0;
    localparam int BIT_LCR_EN = 1;
    localparam int BIT_ILP_EN = 2;
    localparam int FLASH_CTRL_W = 3;

    // Field positions of the status register
    localparam int BIT_ST_PWR = 0;
    localparam int BIT_ST_ACC = 1;
    localparam int BIT_ST_LCR = 2;
    localparam int BIT_ST_ILP = 3;
    localparam int BIT_ST_LOW = 4;
    localparam int SEL_LSB = 5;
    localparam int SEL_W = 3;

    // ========================================================
    // Reset values
    localparam logic [2:0] RST_CLK_CTRL = 3'h0;
    localparam logic [1:0] RST_TMR_CUT = 2'h0;
    localparam logic [2:0] RST_FLASH_CTRL = 3'h0;

    // One-hot system clock source codes
    localparam logic [2:0] SEL_SUB = 3'h1;
    localparam logic [2:0] SEL_OSC_LOW = 3'h2;
    localparam logic [2:0] SEL_OSC_HIGH = 3'h4;

    // Divider: f2, f4, f8 and f32 come from counter bits 0, 1, 2 and 4
    localparam int DIV_W = 5;
    localparam int NUM_DIV = 4;

endpackage

// ### logic/lpgc_clk_gate.sv
// Latch based clock gate for one clock.
// Assumes the enable is a synchronous signal of clk_in.
module lpgc_clk_gate (
    // Clock in and enable
    input wire logic clk_in,
    input wire logic enable,
    // Gated clock
    output logic clk_out
);

    logic en_latched;

    // Enable only passes while the clock is low, so the output never chops a pulse
    always_latch begin
        if (!clk_in) begin
            en_latched = enable;
        end
    end

    assign clk_out = clk_in & en_latched;

endmodule

// ### logic/lpgc_ctrl.sv
// Power reduction control: peripheral clock gating in wait, timer count
// source cutoff, flash stop and auto power-off, low current read,
// internal low power in wait, and system clock source selection.
// Assumes wait_mode, stop_mode and cpu_rewrite_en come from core_clk logic.
//
// Functional notes
// - Peripheral stop bit halts f1, f2, f4, f8, f32 throughout wait mode; here f2 to f32 first finish any high phase under way at wait entry.
// - First timer cutoff bit blocks that timer's count source clock.
// - Second timer cutoff bit blocks that timer's count source clock.
// - Flash stop bit stops flash; every flash access disabled while set.
// - Flash stop intended for low-speed clock and low-speed oscillator modes.
// - Stop or wait without rewrite mode cuts flash power; exit restores it.
// - Low current read bit reduces flash read current in low-speed modes.
// - Internal low power bit reduces supply use in wait entered from low speed.
// - Source bit 0 selects sub clock; 1 selects oscillator, speed bit low/high.
//
// Design decisions made here: the plain strobed port and the register offsets.
module lpgc_ctrl (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Register port
    input wire logic [lpgc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [lpgc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [lpgc_pkg::DATA_W-1:0] reg_rdata,
    // Core power state
    input wire logic wait_mode,
    input wire logic stop_mode,
    input wire logic cpu_rewrite_en,
    // Peripheral and timer clocks
    output logic clk_f1,
    output logic clk_f2,
    output logic clk_f4,
    output logic clk_f8,
    output logic clk_f32,
    output logic timer_a_count_clk,
    output logic timer_b_count_clk,
    // Flash controls
    output logic flash_power_on,
    output logic flash_access_en,
    output logic flash_low_current_read,
    // Internal supply and clock source
    output logic internal_low_power,
    output logic sel_sub_clock,
    output logic sel_osc_low,
    output logic sel_osc_high
);

    // ========================================================
    // State
    typedef struct packed {
        logic [lpgc_pkg::CLK_CTRL_W-1:0] clk_ctrl;
        logic [lpgc_pkg::TMR_CUT_W-1:0] tmr_cut;
        logic [lpgc_pkg::FLASH_CTRL_W-1:0] flash_ctrl;
        logic [lpgc_pkg::DIV_W-1:0] cnt;
        logic [lpgc_pkg::NUM_DIV-1:0] div_en;
        logic [lpgc_pkg::NUM_DIV-1:0] div_out;
        logic [lpgc_pkg::SEL_W-1:0] sel;
        logic flash_pwr;
        logic flash_acc;
        logic lcr_act;
        logic ilp_act;
        logic wait_prev;
        logic wait_from_low;
        logic [lpgc_pkg::DATA_W-1:0] rdata;
    } lpgc_state_t;

    lpgc_state_t st;
    lpgc_state_t next_st;

    logic periph_halt;
    logic low_speed;
    logic [lpgc_pkg::SEL_W-1:0] sel_target;
    logic [2:0] gate_en;
    logic [2:0] gated_clk;
    logic [lpgc_pkg::DIV_W-1:0] cnt_next;
    logic [lpgc_pkg::NUM_DIV-1:0] div_src;

    // ========================================================
    // Decoded controls
    // Peripheral clocks stop only while the core is actually waiting
    assign periph_halt = wait_mode && st.clk_ctrl[lpgc_pkg::BIT_PERIPH_STOP];
    // Sub clock and low-speed oscillator both count as low-speed modes
    assign low_speed = (st.sel != lpgc_pkg::SEL_OSC_HIGH);

    // Source code from the two select bits
    always_comb begin
        if (!st.clk_ctrl[lpgc_pkg::BIT_SRC_SEL]) begin
            sel_target = lpgc_pkg::SEL_SUB;
        end else if (!st.clk_ctrl[lpgc_pkg::BIT_OSC_SPEED]) begin
            sel_target = lpgc_pkg::SEL_OSC_LOW;
        end else begin
            sel_target = lpgc_pkg::SEL_OSC_HIGH;
        end
    end

    // Enables of f1 and the two timer count sources
    assign gate_en[0] = !periph_halt;
    assign gate_en[1] = !st.tmr_cut[lpgc_pkg::BIT_CUT_A];
    assign gate_en[2] = !st.tmr_cut[lpgc_pkg::BIT_CUT_B];

    // ========================================================
    // Gated core clock copies
    for (genvar g = 0; g < 3; g++) begin : gen_gate
        lpgc_clk_gate u_gate (
            .clk_in(core_clk),
            .enable(gate_en[g]),
            .clk_out(gated_clk[g])
        );
    end

    // Timer count sources derive from f1 speed but ignore wait gating
    assign clk_f1 = gated_clk[0];
    assign timer_a_count_clk = gated_clk[1];
    assign timer_b_count_clk = gated_clk[2];

    // ========================================================
    // Divider taps
    assign cnt_next = st.cnt + 5'h01;
    assign div_src = {cnt_next[4], cnt_next[2], cnt_next[1], cnt_next[0]};

    // ========================================================
    // Next state
    always_comb begin
        next_st = st;
        next_st.rdata = '0;

        // Register writes
        if (reg_wr) begin
            unique case (reg_addr)
                lpgc_pkg::OFS_CLK_CTRL:
                    next_st.clk_ctrl = reg_wdata[lpgc_pkg::CLK_CTRL_W-1:0];
                lpgc_pkg::OFS_TMR_CUT:
                    next_st.tmr_cut = reg_wdata[lpgc_pkg::TMR_CUT_W-1:0];
                lpgc_pkg::OFS_FLASH_CTRL:
                    next_st.flash_ctrl = reg_wdata[lpgc_pkg::FLASH_CTRL_W-1:0];
                default: begin
                end
            endcase
        end

        // Register reads, answered in the next cycle; unmapped reads as zero
        if (reg_rd) begin
            unique case (reg_addr)
                lpgc_pkg::OFS_CLK_CTRL:
                    next_st.rdata[lpgc_pkg::CLK_CTRL_W-1:0] = st.clk_ctrl;
                lpgc_pkg::OFS_TMR_CUT:
                    next_st.rdata[lpgc_pkg::TMR_CUT_W-1:0] = st.tmr_cut;
                lpgc_pkg::OFS_FLASH_CTRL:
                    next_st.rdata[lpgc_pkg::FLASH_CTRL_W-1:0] = st.flash_ctrl;
                lpgc_pkg::OFS_STATUS: begin
                    next_st.rdata[lpgc_pkg::BIT_ST_PWR] = st.flash_pwr;
                    next_st.rdata[lpgc_pkg::BIT_ST_ACC] = st.flash_acc;
                    next_st.rdata[lpgc_pkg::BIT_ST_LCR] = st.lcr_act;
                    next_st.rdata[lpgc_pkg::BIT_ST_ILP] = st.ilp_act;
                    next_st.rdata[lpgc_pkg::BIT_ST_LOW] = low_speed;
                    next_st.rdata[lpgc_pkg::SEL_LSB +: lpgc_pkg::SEL_W] = st.sel;
                end
                default: begin
                end
            endcase
        end

        // Divider runs free; each tap re-decides its enable only at a low phase
        next_st.cnt = cnt_next;
        for (int i = 0; i < lpgc_pkg::NUM_DIV; i++) begin
            if (!div_src[i]) begin
                next_st.div_en[i] = !periph_halt;
            end
            next_st.div_out[i] = div_src[i] && next_st.div_en[i];
        end

        // Break before make: drop the old source one cycle before the new one
        if (st.sel != sel_target) begin
            next_st.sel = (st.sel != '0) ? '0 : sel_target;
        end

        // Flash power follows stop or wait unless rewrite mode is on
        next_st.flash_pwr = !((wait_mode || stop_mode) && !cpu_rewrite_en);
        // Flash reachable only when powered and not stopped
        next_st.flash_acc = next_st.flash_pwr
            && !st.flash_ctrl[lpgc_pkg::BIT_FLASH_STOP];
        next_st.lcr_act = st.flash_ctrl[lpgc_pkg::BIT_LCR_EN] && low_speed;

        // Low-speed mode is caught at wait entry, since the source may move later
        next_st.wait_prev = wait_mode;
        if (wait_mode && !st.wait_prev) begin
            next_st.wait_from_low = low_speed;
        end
        next_st.ilp_act = wait_mode && st.flash_ctrl[lpgc_pkg::BIT_ILP_EN]
            && (st.wait_prev ? st.wait_from_low : low_speed);
    end

    // ========================================================
    // State register
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
            st.clk_ctrl <= lpgc_pkg::RST_CLK_CTRL;
            st.tmr_cut <= lpgc_pkg::RST_TMR_CUT;
            st.flash_ctrl <= lpgc_pkg::RST_FLASH_CTRL;
            st.sel <= lpgc_pkg::SEL_SUB;
            st.flash_pwr <= 1'b1;
            st.flash_acc <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ========================================================
    // Outputs, all from flip-flops except the latch gated clocks
    assign reg_rdata = st.rdata;
    assign clk_f2 = st.div_out[0];
    assign clk_f4 = st.div_out[1];
    assign clk_f8 = st.div_out[2];
    assign clk_f32 = st.div_out[3];
    assign flash_power_on = st.flash_pwr;
    assign flash_access_en = st.flash_acc;
    assign flash_low_current_read = st.lcr_act;
    assign internal_low_power = st.ilp_act;
    assign sel_sub_clock = st.sel[0];
    assign sel_osc_low = st.sel[1];
    assign sel_osc_high = st.sel[2];

    // ========================================================
    // Assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    // Halt held long enough for the f4 high phase to finish
    sequence s_halt_held;
        periph_halt [*5];
    endsequence

    sequence s_cut_a_write;
        reg_wr && reg_addr == lpgc_pkg::OFS_TMR_CUT && reg_wdata[lpgc_pkg::BIT_CUT_A];
    endsequence

    sequence s_cut_b_write;
        reg_wr && reg_addr == lpgc_pkg::OFS_TMR_CUT && reg_wdata[lpgc_pkg::BIT_CUT_B];
    endsequence

    a_fast_taps_halt: assert property (s_halt_held |-> !clk_f2 && !clk_f4)
        else $error("f2 or f4 still running during wait halt");

    a_f1_gate_off: assert property ($rose(periph_halt) |-> !gate_en[0])
        else $error("f1 enable on while halted in wait");

    a_timer_a_cut: assert property (s_cut_a_write |=> !gate_en[1])
        else $error("timer a count source not cut after write");

    a_timer_b_cut: assert property (s_cut_b_write |=> !gate_en[2])
        else $error("timer b count source not cut after write");

    a_flash_stop_block: assert property (
        $past(st.flash_ctrl[lpgc_pkg::BIT_FLASH_STOP]) |-> !flash_access_en)
        else $error("flash access enabled while stopped");

    a_flash_auto_off: assert property (
        (stop_mode || wait_mode) && !cpu_rewrite_en |=> !flash_power_on ##0 !flash_access_en)
        else $error("flash power not cut in stop or wait");

    a_flash_auto_on: assert property (
        !stop_mode && !wait_mode |=> flash_power_on)
        else $error("flash power not restored on exit");

    a_low_current_rd: assert property (
        flash_low_current_read |-> $past(st.flash_ctrl[lpgc_pkg::BIT_LCR_EN]))
        else $error("low current read active without enable");

    a_ilp_wait_only: assert property (internal_low_power |-> $past(wait_mode))
        else $error("internal low power outside wait");

    a_src_follow: assert property (
        $stable(sel_target) [*3] |-> st.sel == sel_target)
        else $error("clock source not following select bits");

    a_src_one_hot: assert property ($onehot0(st.sel))
        else $error("two clock sources selected at once");

    a_src_break: assert property (
        st.sel != '0 && $changed(st.sel) |-> $past(st.sel) == '0)
        else $error("clock source switched without a dead cycle");

    // The f8 tap may need a whole high phase of four cycles before it parks low
    a_slow_tap_halt: assert property (periph_halt [*8] |-> !clk_f8)
        else $error("f8 still running during wait halt");

    a_ilp_needs_en: assert property (
        internal_low_power |-> $past(st.flash_ctrl[lpgc_pkg::BIT_ILP_EN]))
        else $error("internal low power active without enable");

    a_acc_needs_pwr: assert property (flash_access_en |-> flash_power_on)
        else $error("flash access enabled while flash unpowered");

    a_lcr_low_speed: assert property (flash_low_current_read |-> $past(low_speed))
        else $error("low current read active in high-speed mode");

    // Read data stand for exactly one cycle, so idle cycles must read as zero
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data present without a read strobe");

endmodule

// ### verif/tb.sv
// Self-checking bench for the low power gating control block.
// Assumes lpgc_pkg and lpgc_ctrl are compiled first; one 200 MHz clock.
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ====================================================
    // Bench signals
    typedef struct packed {
        logic [1:0] k;
        logic [31:0] e;
    } lpgc_note_t;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic wait_mode = 1'b0;
    logic stop_mode = 1'b0;
    logic cpu_rewrite_en = 1'b0;
    logic clk_f1, clk_f2, clk_f4, clk_f8, clk_f32, tmr_a, tmr_b;
    logic flash_power_on, flash_access_en, flash_low_current_read;
    logic internal_low_power, sel_sub_clock, sel_osc_low, sel_osc_high;
    logic rd_q = 1'b0;
    logic chk_req = 1'b0;
    logic [6:0] ran = 7'h00;
    logic [31:0] d;
    int unsigned seed_v;
    int ecnt [7];
    int n_mismatch = 0;
    int cmp_count = 0;
    realtime t_up = 0.0;
    lpgc_note_t notes [$];
    logic [7:0] ofs [3] = '{lpgc_pkg::OFS_CLK_CTRL, lpgc_pkg::OFS_TMR_CUT,
                            lpgc_pkg::OFS_FLASH_CTRL};
    logic [31:0] msk [3] = '{32'h7, 32'h3, 32'h7};
    logic [31:0] src [3] = '{32'h0, 32'h2, 32'h6};
    logic [2:0] sl [3] = '{3'h1, 3'h2, 3'h4};
    wire [6:0] gclk = {tmr_b, tmr_a, clk_f32, clk_f8, clk_f4, clk_f2, clk_f1};
    // Level outputs packed like the status word, without the low-speed bit
    wire [6:0] lv = {sel_osc_high, sel_osc_low, sel_sub_clock, internal_low_power,
                     flash_low_current_read, flash_access_en, flash_power_on};

    // ====================================================
    // Clock and design
    always #2.5 core_clk = ~core_clk;

    lpgc_ctrl u_dut (
        .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wait_mode(wait_mode),
        .stop_mode(stop_mode), .cpu_rewrite_en(cpu_rewrite_en), .clk_f1(clk_f1),
        .clk_f2(clk_f2), .clk_f4(clk_f4), .clk_f8(clk_f8), .clk_f32(clk_f32),
        .timer_a_count_clk(tmr_a), .timer_b_count_clk(tmr_b),
        .flash_power_on(flash_power_on), .flash_access_en(flash_access_en),
        .flash_low_current_read(flash_low_current_read),
        .internal_low_power(internal_low_power), .sel_sub_clock(sel_sub_clock),
        .sel_osc_low(sel_osc_low), .sel_osc_high(sel_osc_high)
    );

    // ====================================================
    // Edge counters; a window only asks whether a clock ran at all
    for (genvar i = 0; i < 7; i++) begin : g_cnt
        always @(posedge gclk[i]) ecnt[i] <= ecnt[i] + 1;
    end

    // A shortened high pulse on the gated clock would clock logic twice
    always @(posedge clk_f1) t_up = $realtime;
    always @(negedge clk_f1) if (rstn) cmp("f1_high", 32'(($realtime - t_up) > 2.4), 32'h1);

    // ====================================================
    // Shared tasks
    task automatic cmp(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        notes.push_back('{2'h0, e});
        @(posedge core_clk);
        reg_rd <= 1'b0;
    endtask

    task automatic chk(input logic [1:0] k, input logic [6:0] e);
        @(posedge core_clk);
        chk_req <= 1'b1;
        notes.push_back('{k, {25'h0, e}});
        @(posedge core_clk);
        chk_req <= 1'b0;
    endtask

    // Let divided clocks settle past a half period, then watch 64 cycles
    task automatic win(input logic [6:0] e);
        int s [7];
        repeat (40) @(posedge core_clk);
        s = ecnt;
        repeat (64) @(posedge core_clk);
        for (int i = 0; i < 7; i++) ran[i] = (ecnt[i] != s[i]);
        chk(2'h2, e);
    endtask

    task automatic print_verdict();
        if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // ====================================================
    // Monitor: each result is matched with the oldest note
    always @(posedge core_clk) begin
        lpgc_note_t n;
        rd_q <= reg_rd;
        if (rd_q || chk_req) begin
            if (notes.size() == 0) begin
                cmp("note_queue", 32'h0, 32'h1);
            end else begin
                n = notes.pop_front();
                case (n.k)
                    2'h0: cmp("reg_rdata", reg_rdata, n.e);
                    2'h1: cmp("levels", {25'h0, lv}, n.e);
                    default: cmp("clock_run", {25'h0, ran}, n.e);
                endcase
            end
        end
    end

    // Watchdog: the whole sequence needs about 1,000 cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        print_verdict();
    end

    // ====================================================
    // Main sequence
    initial begin
        seed_v = $urandom(32'h26F61D3C);
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        // Reset state and an unmapped read
        for (int i = 0; i < 3; i++) rd(ofs[i], 32'h0);
        rd(8'h10, 32'h0);
        rd(lpgc_pkg::OFS_STATUS, 32'h33);
        chk(2'h1, 7'h13);
        // Random data back; only the defined low bits are kept
        for (int i = 0; i < 3; i++) begin
            d = $urandom();
            wr(ofs[i], d);
            rd(ofs[i], d & msk[i]);
        end
        wr(8'h14, $urandom());
        rd(8'h14, 32'h0);
        for (int i = 0; i < 3; i++) wr(ofs[i], 32'h0);
        // Every source setting, outputs and status
        for (int k = 0; k < 3; k++) begin
            wr(lpgc_pkg::OFS_CLK_CTRL, src[k]);
            repeat (4) @(posedge core_clk);
            chk(2'h1, {sl[k], 4'h3});
            rd(lpgc_pkg::OFS_STATUS, {24'h0, sl[k], k < 2, 4'h3});
        end
        // Low current read only counts in a low-speed mode
        wr(lpgc_pkg::OFS_FLASH_CTRL, 32'h2);
        repeat (2) @(posedge core_clk);
        chk(2'h1, {3'h4, 4'h3});
        wr(lpgc_pkg::OFS_CLK_CTRL, 32'h2);
        repeat (4) @(posedge core_clk);
        chk(2'h1, {3'h2, 4'h7});
        // Wait from low speed: flash off, internal low power on
        wr(lpgc_pkg::OFS_FLASH_CTRL, 32'h4);
        wait_mode <= 1'b1;
        chk(2'h1, {3'h2, 4'h8});
        wait_mode <= 1'b0;
        chk(2'h1, {3'h2, 4'h3});
        wr(lpgc_pkg::OFS_CLK_CTRL, 32'h6);
        repeat (4) @(posedge core_clk);
        wait_mode <= 1'b1;
        chk(2'h1, {3'h4, 4'h0});
        // Stop with rewrite mode keeps flash powered, without it cuts power
        wait_mode <= 1'b0;
        cpu_rewrite_en <= 1'b1;
        stop_mode <= 1'b1;
        chk(2'h1, {3'h4, 4'h3});
        cpu_rewrite_en <= 1'b0;
        chk(2'h1, {3'h4, 4'h0});
        stop_mode <= 1'b0;
        chk(2'h1, {3'h4, 4'h3});
        // Flash stop blocks access, also after a wait cycle
        wr(lpgc_pkg::OFS_FLASH_CTRL, 32'h1);
        repeat (2) @(posedge core_clk);
        chk(2'h1, {3'h4, 4'h1});
        wait_mode <= 1'b1;
        chk(2'h1, {3'h4, 4'h0});
        wait_mode <= 1'b0;
        chk(2'h1, {3'h4, 4'h1});
        wr(lpgc_pkg::OFS_FLASH_CTRL, 32'h0);
        // Peripheral clocks in wait, and the two timer cutoffs
        wr(lpgc_pkg::OFS_CLK_CTRL, 32'h1);
        wait_mode <= 1'b1;
        win(7'h60);
        wr(lpgc_pkg::OFS_CLK_CTRL, 32'h0);
        win(7'h7F);
        wait_mode <= 1'b0;
        wr(lpgc_pkg::OFS_CLK_CTRL, 32'h1);
        win(7'h7F);
        wr(lpgc_pkg::OFS_TMR_CUT, 32'h1);
        win(7'h5F);
        wr(lpgc_pkg::OFS_TMR_CUT, 32'h2);
        win(7'h3F);
        wr(lpgc_pkg::OFS_TMR_CUT, 32'h3);
        wait_mode <= 1'b1;
        win(7'h00);
        wait_mode <= 1'b0;
        win(7'h1F);
        print_verdict();
    end
endmodule
